// ---- accel_mode_control_defs.vh ----
/*
  Register offsets, field positions, codes, reset values and timing
  figures used by the mode control block, not by its sample FIFO.
  Assumes inclusion by bare name from files in the same folder.
*/
`ifndef ACCEL_MODE_CONTROL_DEFS_VH
`define ACCEL_MODE_CONTROL_DEFS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ADDR_FEATURE_TWO 8'h0e
`define ADDR_INIT_KEY 8'h0f
`define ADDR_MODE_CTRL 8'h10

// ----------------------------------------
// field positions
// ----------------------------------------
`define FS2_STREAM_BIT 5
`define FS2_POLARITY_BIT 6
`define FS2_EXT_ON_BIT 7
`define MC_RESERVED_BIT 3
`define MC_X_PD_BIT 4
`define MC_Y_PD_BIT 5
`define MC_Z_PD_BIT 6
`define MC_GO_BIT 7

// ----------------------------------------
// reset values
// ----------------------------------------
`define FS2_RESET 8'h00
`define MC_RESET 8'h00

// ----------------------------------------
// mode codes
// ----------------------------------------
`define MODE_SLEEP 3'h0
`define MODE_STANDBY 3'h1
`define MODE_WATCH 3'h2
`define MODE_RSVD_A 3'h3
`define MODE_RSVD_B 3'h4
`define MODE_CONT 3'h5
`define MODE_WATCH_SAMPLE 3'h6
`define MODE_BURST 3'h7

// ----------------------------------------
// init key values and continuous burst length
// ----------------------------------------
`define INIT_KEY_VALUE 8'h42
`define INIT_RB_STARTUP 8'h45
`define INIT_RB_READY 8'h40
`define INIT_RB_KEYED 8'h43
`define BURST_CONTINUOUS 8'hff

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_KHZ 10000
`define STATUS_LAG_MS 2
`define HB_APPLY_TICKS 2
`define HEARTBEAT_DIV 16
`define STARTUP_CYCLES 64

`endif

// ---- sample_fifo.v ----
/*
  Sample FIFO with registered output stage, optional overwrite of the
  oldest entry when full, and a discard path when storage is off.
  Assumes one clock, synchronous active-low reset, power-of-two free.
*/
`timescale 1ns/1ps

module sample_fifo #(
  parameter WIDTH = 16,
  parameter integer DEPTH = 8,
  parameter AW = 3
) (
  // clock and reset
  input wire clk,
  input wire resetn,
  // control
  input wire store_en,
  input wire overwrite,
  // fill side
  input wire push_valid,
  input wire [WIDTH-1:0] push_data,
  output reg push_ready,
  // drain side
  output reg pop_valid,
  output reg [WIDTH-1:0] pop_data,
  input wire pop_ready,
  // status
  output reg full,
  output reg empty
);

  localparam integer LAST_INT = DEPTH - 1;
  localparam [AW:0] FULL_COUNT = DEPTH[AW:0];
  localparam [AW-1:0] LAST_PTR = LAST_INT[AW-1:0];

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] mcount;
  reg [AW:0] next_count;
  reg next_pop_valid;
  wire load_out;
  wire do_push;
  wire drop;
  wire advance;

  // pointer step with wrap
  function [AW-1:0] step;
    input [AW-1:0] p;
    begin
      step = (p == LAST_PTR) ? {AW{1'b0}} : p + 1'b1;
    end
  endfunction

  // move, push and drop decisions
  assign load_out = (mcount != {(AW+1){1'b0}}) && (!pop_valid || pop_ready);
  assign do_push = push_valid && push_ready && store_en &&
                   ((mcount != FULL_COUNT) || overwrite);
  assign drop = do_push && (mcount == FULL_COUNT) && !load_out;
  assign advance = load_out || drop;

  // occupancy after this edge
  always @* begin
    next_count = mcount;
    if (do_push && !advance) begin
      next_count = mcount + 1'b1;
    end else if (!do_push && advance) begin
      next_count = mcount - 1'b1;
    end
    next_pop_valid = load_out ? 1'b1 : (pop_ready ? 1'b0 : pop_valid);
  end

  // storage without reset
  always @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr] <= push_data;
    end
    if (load_out) begin
      pop_data <= mem[rd_ptr];
    end
  end

  // pointers, count and flags
  always @(posedge clk) begin
    if (!resetn) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      mcount <= {(AW+1){1'b0}};
      pop_valid <= 1'b0;
      push_ready <= 1'b1;
      full <= 1'b0;
      empty <= 1'b1;
    end else begin
      if (do_push) begin
        wr_ptr <= step(wr_ptr);
      end
      if (advance) begin
        rd_ptr <= step(rd_ptr);
      end
      mcount <= next_count;
      pop_valid <= next_pop_valid;
      full <= (next_count == FULL_COUNT);
      empty <= (next_count == {(AW+1){1'b0}}) && !next_pop_valid;
      push_ready <= !store_en || overwrite || (next_count != FULL_COUNT);
    end
  end

endmodule

// ---- accel_mode_control.v ----
/*
  Mode control of a three-axis motion sensor: register port for the
  feature, init key and mode registers, heartbeat-paced mode machine,
  counted bursts, external trigger on the interrupt pin, sample FIFO.
  Assumes a serial front end that turns host frames into register
  strobes on this clock, and a sample pipeline on the same clock.
*/
`timescale 1ns/1ps
`include "accel_mode_control_defs.vh"

module accel_mode_control #(
  parameter WIDTH = 16,
  parameter integer DEPTH = 8,
  parameter AW = 3,
  parameter integer STATUS_LAG_CYCLES = `STATUS_LAG_MS * `CLK_KHZ,
  parameter integer HEARTBEAT_DIV = `HEARTBEAT_DIV,
  parameter integer STARTUP_CYCLES = `STARTUP_CYCLES
) (
  // clock and reset
  input wire clk,
  input wire resetn,
  // register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  output reg reg_rvalid,
  // neighbouring register bits and events
  input wire fifo_enable,
  input wire [7:0] burst_length,
  input wire activity_detect,
  input wire irq_request,
  // interrupt pin, two-way
  input wire irq_in,
  output reg irq_out,
  output reg irq_oe,
  // sample pipeline
  input wire sample_valid,
  input wire [WIDTH-1:0] sample_data,
  output wire sample_ready,
  output reg sample_request,
  // sample readout
  output wire fifo_valid,
  output wire [WIDTH-1:0] fifo_data,
  input wire fifo_ready,
  output wire fifo_full,
  output wire fifo_empty,
  // mode and power state
  output reg [2:0] op_mode,
  output reg [2:0] mode_status,
  output reg clocks_on,
  output reg sniff_on,
  output reg xyz_on,
  output reg x_power_down,
  output reg y_power_down,
  output reg z_power_down
);

  // ----------------------------------------
  // constants
  // ----------------------------------------
  localparam [31:0] LAG_LAST = STATUS_LAG_CYCLES - 1;
  localparam [31:0] HB_LAST = HEARTBEAT_DIV - 1;
  localparam [31:0] START_LAST = STARTUP_CYCLES - 1;
  localparam integer HB_APPLY_INT = `HB_APPLY_TICKS;
  localparam [1:0] HB_APPLY = HB_APPLY_INT[1:0];

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg [7:0] feature_select_two;
  reg [2:0] mode_select_field;
  reg pend;
  reg pend_one_shot;
  reg one_shot_active;
  reg [1:0] hb_ticks;
  reg [15:0] hb_cnt;
  reg hb_tick;
  reg [15:0] start_cnt;
  reg startup_done;
  reg init_keyed;
  reg [23:0] lag_cnt;
  reg [7:0] burst_cnt;
  reg counted_burst_meta;
  reg counted_burst_sync;
  reg counted_burst_prev;
  wire wr_feature;
  wire wr_init;
  wire wr_mode;
  wire ext_sample_input_on;
  wire ext_edge_polarity;
  wire stream_on;
  wire counted_burst_edge;
  wire fifo_store;
  wire sample_taken;
  wire burst_done;
  wire auto_wake;

  // true for codes that the mode machine may take
  function valid_mode;
    input [2:0] m;
    begin
      valid_mode = (m != `MODE_RSVD_A) && (m != `MODE_RSVD_B);
    end
  endfunction

  // true for modes in which the XYZ pipeline runs
  function samples_in;
    input [2:0] m;
    begin
      samples_in = (m == `MODE_CONT) || (m == `MODE_WATCH_SAMPLE) ||
                   (m == `MODE_BURST);
    end
  endfunction

  // register strobes
  assign wr_feature = reg_wr && (reg_addr == `ADDR_FEATURE_TWO);
  assign wr_init = reg_wr && (reg_addr == `ADDR_INIT_KEY);
  assign wr_mode = reg_wr && (reg_addr == `ADDR_MODE_CTRL);

  // feature fields
  assign ext_sample_input_on = feature_select_two[`FS2_EXT_ON_BIT];
  assign ext_edge_polarity = feature_select_two[`FS2_POLARITY_BIT];
  assign stream_on = feature_select_two[`FS2_STREAM_BIT];

  // ----------------------------------------
  // heartbeat and start-up
  // ----------------------------------------

  // heartbeat enable pulse from divider
  always @(posedge clk) begin
    if (!resetn) begin
      hb_cnt <= 16'h0000;
      hb_tick <= 1'b0;
    end else if (hb_cnt == HB_LAST[15:0]) begin
      hb_cnt <= 16'h0000;
      hb_tick <= 1'b1;
    end else begin
      hb_cnt <= hb_cnt + 16'h0001;
      hb_tick <= 1'b0;
    end
  end

  // start-up sequence and init key
  always @(posedge clk) begin
    if (!resetn) begin
      start_cnt <= 16'h0000;
      startup_done <= 1'b0;
      init_keyed <= 1'b0;
    end else begin
      if (!startup_done) begin
        start_cnt <= start_cnt + 16'h0001;
        startup_done <= (start_cnt == START_LAST[15:0]);
      end
      if (wr_init && (reg_wdata == `INIT_KEY_VALUE)) begin
        init_keyed <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // register reads and feature register
  // ----------------------------------------

  // read answer one cycle after the strobe
  always @(posedge clk) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
      feature_select_two <= `FS2_RESET;
    end else begin
      reg_rvalid <= reg_rd;
      if (wr_feature) begin
        feature_select_two <= reg_wdata;
      end
      if (reg_rd) begin
        case (reg_addr)
          `ADDR_FEATURE_TWO: begin
            reg_rdata <= feature_select_two;
          end
          `ADDR_INIT_KEY: begin
            reg_rdata <= init_keyed ? `INIT_RB_KEYED :
                         (startup_done ? `INIT_RB_READY : `INIT_RB_STARTUP);
          end
          default: begin
            reg_rdata <= 8'h00;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // mode machine
  // ----------------------------------------

  // samples counted only while a burst runs
  assign sample_taken = sample_valid && sample_ready && (op_mode == `MODE_BURST);
  assign burst_done = sample_taken && (burst_length != `BURST_CONTINUOUS) &&
                      ((burst_cnt + 8'h01) >= burst_length);
  assign auto_wake = activity_detect && (op_mode == `MODE_WATCH);

  // commanded and automatic mode changes
  always @(posedge clk) begin
    if (!resetn) begin
      mode_select_field <= `MODE_SLEEP;
      op_mode <= `MODE_SLEEP;
      pend <= 1'b0;
      pend_one_shot <= 1'b0;
      one_shot_active <= 1'b0;
      hb_ticks <= 2'h0;
      burst_cnt <= 8'h00;
      x_power_down <= 1'b0;
      y_power_down <= 1'b0;
      z_power_down <= 1'b0;
    end else begin
      if (sample_taken) begin
        burst_cnt <= burst_cnt + 8'h01;
      end
      if (auto_wake) begin
        op_mode <= `MODE_CONT;
        mode_select_field <= `MODE_CONT;
        pend <= 1'b0;
      end else if (burst_done) begin
        op_mode <= one_shot_active ? `MODE_STANDBY : `MODE_SLEEP;
        mode_select_field <= one_shot_active ? `MODE_STANDBY : `MODE_SLEEP;
        one_shot_active <= 1'b0;
        pend <= 1'b0;
      end else if (wr_mode) begin
        x_power_down <= reg_wdata[`MC_X_PD_BIT];
        y_power_down <= reg_wdata[`MC_Y_PD_BIT];
        z_power_down <= reg_wdata[`MC_Z_PD_BIT];
        if (reg_wdata[`MC_GO_BIT] && (op_mode == `MODE_STANDBY) && !pend) begin
          pend <= 1'b1;
          pend_one_shot <= 1'b1;
          mode_select_field <= `MODE_BURST;
          hb_ticks <= 2'h0;
        end else if (!reg_wdata[`MC_GO_BIT] && valid_mode(reg_wdata[2:0])) begin
          pend <= 1'b1;
          pend_one_shot <= 1'b0;
          mode_select_field <= reg_wdata[2:0];
          hb_ticks <= 2'h0;
        end
      end else if (pend && hb_tick) begin
        if (hb_ticks + 2'h1 == HB_APPLY) begin
          op_mode <= mode_select_field;
          one_shot_active <= pend_one_shot;
          burst_cnt <= 8'h00;
          pend <= 1'b0;
        end
        hb_ticks <= hb_ticks + 2'h1;
      end
    end
  end

  always @(posedge clk) begin
    if (!resetn) begin
      lag_cnt <= 24'h000000;
      mode_status <= `MODE_SLEEP;
    end else if (mode_status == op_mode) begin
      lag_cnt <= 24'h000000;
    end else if (lag_cnt == LAG_LAST[23:0]) begin
      lag_cnt <= 24'h000000;
      mode_status <= op_mode;
    end else begin
      lag_cnt <= lag_cnt + 24'h000001;
    end
  end

  always @(posedge clk) begin
    if (!resetn) begin
      clocks_on <= 1'b0;
      sniff_on <= 1'b0;
      xyz_on <= 1'b0;
    end else begin
      clocks_on <= (op_mode != `MODE_SLEEP);
      sniff_on <= (op_mode == `MODE_WATCH) || (op_mode == `MODE_WATCH_SAMPLE);
      xyz_on <= samples_in(op_mode);
    end
  end

  // ----------------------------------------
  // external trigger on the interrupt pin
  // ----------------------------------------

  // pin synchroniser and edge history
  always @(posedge clk) begin
    if (!resetn) begin
      counted_burst_meta <= 1'b1;
      counted_burst_sync <= 1'b1;
      counted_burst_prev <= 1'b1;
    end else begin
      counted_burst_meta <= irq_in;
      counted_burst_sync <= counted_burst_meta;
      counted_burst_prev <= counted_burst_sync;
    end
  end

  assign counted_burst_edge = ext_edge_polarity ? (counted_burst_sync && !counted_burst_prev) :
                     (!counted_burst_sync && counted_burst_prev);

  // pin turned input, edges start samples in burst mode
  always @(posedge clk) begin
    if (!resetn) begin
      irq_oe <= 1'b1;
      irq_out <= 1'b1;
      sample_request <= 1'b0;
    end else begin
      irq_oe <= !ext_sample_input_on;
      irq_out <= !irq_request;
      sample_request <= ext_sample_input_on && counted_burst_edge &&
                        (op_mode == `MODE_BURST);
    end
  end

  // ----------------------------------------
  // sample FIFO
  // ----------------------------------------

  // storage needs FIFO enable and a sampling mode
  assign fifo_store = fifo_enable && samples_in(op_mode);

  // no dependence on host interface kind
  sample_fifo #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .store_en(fifo_store),
    .overwrite(stream_on && fifo_enable),
    .push_valid(sample_valid),
    .push_data(sample_data),
    .push_ready(sample_ready),
    .pop_valid(fifo_valid),
    .pop_data(fifo_data),
    .pop_ready(fifo_ready),
    .full(fifo_full),
    .empty(fifo_empty)
  );

endmodule

// ---- accel_mode_control_properties.sv ----
/*
  Port-level checker for the mode control block.
  Assumes a bind onto accel_mode_control, one clock domain.
*/
`timescale 1ns/1ps
module accel_mode_control_properties (
  // clock and reset
  input wire clk,
  input wire resetn,
  // register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire reg_rvalid,
  // pins and samples
  input wire fifo_enable,
  input wire activity_detect,
  input wire irq_in,
  input wire irq_oe,
  input wire sample_ready,
  input wire sample_request,
  input wire fifo_full,
  // mode state
  input wire [2:0] op_mode,
  input wire x_power_down,
  input wire y_power_down,
  input wire z_power_down
);
  reg stream_q;
  reg pol_q;
  reg ext_q;
  wire store = fifo_enable && (op_mode == 3'h5 || op_mode == 3'h6 || op_mode == 3'h7);

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  // ----------------------------------------
  // feature register shadow
  // ----------------------------------------
  // copy of the stream, polarity and trigger bits
  always @(posedge clk) begin
    if (!resetn) begin
      stream_q <= 1'b0;
      pol_q <= 1'b0;
      ext_q <= 1'b0;
    end else if (reg_wr && reg_addr == 8'h0e) begin
      stream_q <= reg_wdata[5];
      pol_q <= reg_wdata[6];
      ext_q <= reg_wdata[7];
    end
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read strobe without answer");
  a_answer_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("answer without read strobe");
  a_axis_bits: assert property (reg_wr && reg_addr == 8'h10 |=>
    {z_power_down, y_power_down, x_power_down} == $past(reg_wdata[6:4]))
    else $error("axis power-down bits not taken");
  a_full_stops: assert property ((store && !stream_q) ##1 fifo_full |-> !sample_ready)
    else $error("full FIFO still accepts");
  a_stream_moves: assert property ((store && stream_q && fifo_full)[*2] |=> sample_ready)
    else $error("stream FIFO refuses when full");
  a_pin_input: assert property ($stable(ext_q) && $past(ext_q) == $past(ext_q, 2)
    |-> irq_oe == !ext_q)
    else $error("pin drive does not follow trigger enable");
  a_rise_request: assert property (ext_q && pol_q && op_mode == 3'h7 && $rose(irq_in)
    |-> ##[3:4] sample_request)
    else $error("rising edge missed");
  a_fall_request: assert property (ext_q && !pol_q && op_mode == 3'h7 && $fell(irq_in)
    |-> ##[3:4] sample_request)
    else $error("falling edge missed");
  a_request_cause: assert property (sample_request |-> $past(op_mode) == 3'h7 && $past(ext_q))
    else $error("sample request outside trigger mode");
  a_watch_wakes: assert property (op_mode == 3'h2 && activity_detect |=> op_mode == 3'h5)
    else $error("activity did not wake");
  a_no_reserved: assert property (op_mode != 3'h3 && op_mode != 3'h4)
    else $error("reserved mode entered");

  c_read: cover property (reg_rd ##1 reg_rvalid);
  c_full: cover property (fifo_full && stream_q);
  c_trigger: cover property (sample_request);
endmodule

bind accel_mode_control accel_mode_control_properties accel_mode_control_properties_inst (
  .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rvalid(reg_rvalid), .fifo_enable(fifo_enable),
  .activity_detect(activity_detect), .irq_in(irq_in), .irq_oe(irq_oe),
  .sample_ready(sample_ready), .sample_request(sample_request), .fifo_full(fifo_full),
  .op_mode(op_mode), .x_power_down(x_power_down), .y_power_down(y_power_down),
  .z_power_down(z_power_down));

// ---- host_port_model.sv ----
/*
  Host side of the register port: one-cycle strobes.
  Assumes the bench calls its tasks; strobes change at falling edges.
*/
`timescale 1ns/1ps
module host_port_model (
  // clock
  input wire clk,
  // register strobes
  output reg [7:0] reg_addr,
  output reg [7:0] reg_wdata,
  output reg reg_wr,
  output reg reg_rd
);
  // quiet port at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // one write, released values inverted
  task write(input [7:0] a, input [7:0] d);
    begin
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
    end
  endtask

  // one read strobe
  task read(input [7:0] a);
    begin
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      reg_addr = ~a;
    end
  endtask

  task init_key;
    write(8'h0f, 8'h42);
  endtask
endmodule

// ---- accel_mode_control_test.sv ----
/*
  Self-checking bench for the mode control block.
  Assumes the design, checker and host model files in this folder.
*/
`timescale 1ns/1ps
module accel_mode_control_test;
  localparam HB = 4;
  localparam LAG = 20;
  reg clk, resetn, fifo_enable, activity_detect, irq_request, counted_burst_drv, sample_valid, fifo_ready;
  reg [7:0] burst_length;
  reg [15:0] sample_data;
  reg [31:0] seed;
  reg [2:0] m;
  reg [17:0] seq;
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  wire reg_wr, reg_rd, reg_rvalid, irq_in, irq_out, irq_oe, sample_ready, sample_request;
  wire fifo_valid, fifo_full, fifo_empty, clocks_on, sniff_on, xyz_on;
  wire x_power_down, y_power_down, z_power_down;
  wire [15:0] fifo_data;
  wire [2:0] op_mode, mode_status;
  integer err_total, n_tests, cyc, i, j, k;
  reg [7:0] exp_rd[$];
  reg [15:0] exp_fifo[$];
  reg [15:0] acc[$];

  // pin level from whichever side drives it
  assign irq_in = irq_oe ? irq_out : counted_burst_drv;

  host_port_model host_port_model_inst (.clk(clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

  accel_mode_control #(.STATUS_LAG_CYCLES(LAG), .HEARTBEAT_DIV(HB), .STARTUP_CYCLES(8))
  accel_mode_control_inst (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .fifo_enable(fifo_enable), .burst_length(burst_length),
    .activity_detect(activity_detect), .irq_request(irq_request), .irq_in(irq_in),
    .irq_out(irq_out), .irq_oe(irq_oe), .sample_valid(sample_valid),
    .sample_data(sample_data), .sample_ready(sample_ready), .sample_request(sample_request),
    .fifo_valid(fifo_valid), .fifo_data(fifo_data), .fifo_ready(fifo_ready),
    .fifo_full(fifo_full), .fifo_empty(fifo_empty), .op_mode(op_mode),
    .mode_status(mode_status), .clocks_on(clocks_on), .sniff_on(sniff_on), .xyz_on(xyz_on),
    .x_power_down(x_power_down), .y_power_down(y_power_down), .z_power_down(z_power_down));

  // 100 ns clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task check(input [15:0] seen, input [15:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("Error %0t: saw %h, expected %h", $time, seen, exp);
      end
    end
  endtask

  task end_sim;
    begin
      $display("comparisons %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
        $display("RESULT: PASS");
      end else begin
        $display("RESULT: FAIL");
      end
      $finish;
    end
  endtask

  task wr(input [7:0] a, input [7:0] d);
    host_port_model_inst.write(a, d);
  endtask

  task rd(input [7:0] a, input [7:0] e);
    begin
      exp_rd.push_back(e);
      host_port_model_inst.read(a);
    end
  endtask

  // wait a bounded time for a commanded mode
  task wait_mode(input [2:0] w);
    begin
      i = 0;
      while (op_mode !== w && i < 3 * HB) begin
        @(negedge clk);
        i = i + 1;
      end
      check(op_mode, w);
    end
  endtask

  // offer n random samples, noting those taken
  task push(input integer n);
    begin
      repeat (n) begin
        @(negedge clk);
        seed = lfsr(seed);
        sample_data = seed[15:0];
        sample_valid = 1'b1;
        if (sample_ready === 1'b1) acc.push_back(seed[15:0]);
      end
      @(negedge clk);
      sample_valid = 1'b0;
    end
  endtask

  // read the FIFO out for 30 cycles, then check the notes are used up
  task drain;
    begin
      @(negedge clk);
      fifo_ready = 1'b1;
      repeat (30) @(negedge clk);
      fifo_ready = 1'b0;
      check(exp_fifo.size(), 0);
      check(fifo_empty, 1'b1);
    end
  endtask

  // feed samples until the burst ends, counting those taken
  task run_burst(input [7:0] cmd, input [7:0] n, input [2:0] back);
    begin
      burst_length = n;
      wr(8'h10, cmd);
      wait_mode(3'h7);
      k = 0;
      i = 0;
      @(negedge clk);
      sample_valid = 1'b1;
      while (op_mode === 3'h7 && i < 40) begin
        if (sample_ready === 1'b1) k = k + 1;
        @(negedge clk);
        i = i + 1;
      end
      sample_valid = 1'b0;
      check(k, n);
      check(op_mode, back);
    end
  endtask

  // count trigger requests over eight cycles
  task count_req;
    begin
      k = 0;
      repeat (8) @(negedge clk) if (sample_request === 1'b1) k = k + 1;
    end
  endtask

  // compare results with the oldest notes
  always @(negedge clk) begin
    #10;
    if (reg_rvalid === 1'b1) begin
      if (exp_rd.size() > 0) check(reg_rdata, exp_rd.pop_front());
      else check(1'b0, 1'b1);
    end
    if (fifo_valid === 1'b1 && fifo_ready === 1'b1) begin
      if (exp_fifo.size() > 0) check(fifo_data, exp_fifo.pop_front());
      else check(1'b0, 1'b1);
    end
  end

  // hang guard
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      end_sim;
    end
  end

  // main sequence
  initial begin
    {resetn, activity_detect, irq_request, sample_valid, fifo_ready} = 5'h00;
    {fifo_enable, counted_burst_drv, burst_length, sample_data} = {2'b11, 8'hff, 16'h0000};
    {seed, err_total, n_tests, cyc} = {32'hae52, 96'h0};
    seq = {3'h1, 3'h2, 3'h5, 3'h6, 3'h7, 3'h0};
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    rd(8'h0f, 8'h45);
    repeat (10) @(negedge clk);
    rd(8'h0f, 8'h40);
    wr(8'h0f, 8'h41);
    rd(8'h0f, 8'h40);
    host_port_model_inst.init_key;
    rd(8'h0f, 8'h43);
    rd(8'h10, 8'h00);
    rd(8'h33, 8'h00);
    irq_request = 1'b1;
    repeat (2) @(negedge clk);
    check({irq_oe, irq_out}, 2'b10);
    irq_request = 1'b0;
    seed = lfsr(seed);
    wr(8'h0e, seed[7:0] & 8'h1f);
    rd(8'h0e, seed[7:0] & 8'h1f);
    $display("test registers done");
    for (j = 0; j < 6; j = j + 1) begin
      m = seq[17 - 3 * j -: 3];
      seed = lfsr(seed);
      wr(8'h10, {1'b0, seed[6:4], 1'b1, m});
      wait_mode(m);
      @(negedge clk);
      check({clocks_on, sniff_on, xyz_on}, {m != 0, m == 2 || m == 6, m >= 5});
      i = 0;
      while (mode_status !== m && i < LAG + 4) begin
        @(negedge clk);
        i = i + 1;
      end
      check(mode_status, m);
    end
    wr(8'h10, 8'h01);
    wait_mode(3'h1);
    for (j = 3; j < 5; j = j + 1) begin
      wr(8'h10, j[7:0]);
      repeat (3 * HB + 3) @(negedge clk);
      check(op_mode, 3'h1);
    end
    wr(8'h10, 8'h02);
    wait_mode(3'h2);
    activity_detect = 1'b1;
    @(negedge clk);
    activity_detect = 1'b0;
    check(op_mode, 3'h5);
    $display("test modes done");
    push(12);
    check(acc.size(), 9);
    exp_fifo = acc;
    acc.delete();
    drain;
    wr(8'h0e, 8'h20);
    push(12);
    check(acc.size(), 12);
    exp_fifo.push_back(acc[0]);
    for (j = 4; j < 12; j = j + 1) exp_fifo.push_back(acc[j]);
    acc.delete();
    drain;
    fifo_enable = 1'b0;
    push(3);
    check(fifo_empty, 1'b1);
    acc.delete();
    $display("test fifo done");
    wr(8'h0e, 8'h00);
    wr(8'h10, 8'h01);
    wait_mode(3'h1);
    run_burst(8'h81, 8'h03, 3'h1);
    run_burst(8'h07, 8'h02, 3'h0);
    $display("test bursts done");
    burst_length = 8'hff;
    wr(8'h10, 8'h07);
    wait_mode(3'h7);
    for (j = 1; j >= 0; j = j - 1) begin
      wr(8'h0e, {1'b1, j[0], 6'h00});
      counted_burst_drv = ~j[0];
      repeat (6) @(negedge clk);
      check(irq_oe, 1'b0);
      counted_burst_drv = j[0];
      count_req;
      check(k, 1);
      counted_burst_drv = ~j[0];
      count_req;
      check(k, 0);
    end
    $display("test trigger done");
    end_sim;
  end
endmodule
